// file: design/pcd_defs.svh
// Register offsets, field positions and reset values of the port C/D pin function block
`ifndef PCD_DEFS_SVH
`define PCD_DEFS_SVH
`define PCD_ADR_W 8
`define PCD_OFF_APFS 8'h00
`define PCD_OFF_APDIR 8'h04
`define PCD_OFF_DPDIR 8'h08
`define PCD_OFF_DPFS 8'h0c
`define PCD_OFF_APIN 8'h10
`define PCD_OFF_DPIN 8'h14
`define PCD_OFF_STAT 8'h18
`define PCD_RST_REG 16'h0000
`define PCD_STAT_MODE_LSB 0
`define PCD_STAT_MODE_MSB 1
`define PCD_STAT_DONE_BIT 2
`define PCD_STRAP_CYC 2'h2
`endif

// file: design/pcd_pkg.sv
// Types shared by the port C/D pin function block
package pcd_pkg;
  // Operating mode as strapped on the mode pins, in pin-code order
  typedef enum logic [1:0] {
    PCD_EXT8,
    PCD_EXT16,
    PCD_EXT_ROM,
    PCD_SINGLE
  } pcd_mode_t;
endpackage

// file: design/pcd_sync.sv
// Two-flop synchroniser for pin inputs
module pcd_sync #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  if (W < 1) begin : g_bad_w
    $error("pcd_sync: W must be at least 1");
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// file: design/pcd_pin_mux.sv
// Registered per-pin mux between general I/O and an alternate function
module pcd_pin_mux #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] func_sel,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] gpio_out,
  input wire logic [W-1:0] func_out,
  input wire logic [W-1:0] func_drive,
  output logic [W-1:0] pad_o,
  output logic [W-1:0] pad_oe_n
);
  if (W < 1) begin : g_bad_w
    $error("pcd_pin_mux: W must be at least 1");
  end

  // Pads come out of flops so no glitch reaches the pins on a mode change
  for (genvar i = 0; i < W; i++) begin : g_pin
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        pad_o[i] <= 1'b0;
        pad_oe_n[i] <= 1'b1;
      end else if (func_sel[i]) begin
        pad_o[i] <= func_out[i];
        pad_oe_n[i] <= ~func_drive[i];
      end else begin
        pad_o[i] <= gpio_out[i];
        pad_oe_n[i] <= ~dir[i];
      end
    end
  end
endmodule

// file: design/pcd_pfc.sv
// Pin function control for the address port and the data port, with a Wishbone slave
`include "pcd_defs.svh"

// Operation
// - Address pin function bit 0 gives general I/O, 1 gives its address line.
// - With on-chip ROM disabled every address pin carries its address line.
// - In single-chip mode every address pin stays general I/O.
// - Data port direction register: bit 1 makes the pin an output, 0 an input.
// - Data port direction bits act only on pins working as general I/O.
// - Data port direction register clears only on external power-on reset.
// - Data port function register clears only on external power-on reset.
// - ROM-disabled 8-bit bus mode: data pins are bus lines, function bits ignored.
// - ROM-disabled 16-bit bus mode: data pins are bus lines, function bits ignored.
// - ROM-enabled extended mode: function bits share each data pin individually.
// - Single-chip mode: all data pins are general I/O, function bits ignored.
// - Data pin function bit 0 gives general I/O, 1 gives its data bus line.
// - Address pins as general I/O follow their direction bit, 1 output, 0 input.
module pcd_pfc
  import pcd_pkg::*;
#(
  parameter int PW = 16
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [`PCD_ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [1:0] MODE_PIN,
  input wire logic [PW-1:0] ADDR_PAD_I,
  output logic [PW-1:0] ADDR_PAD_O,
  output logic [PW-1:0] ADDR_PAD_OE_N,
  input wire logic [PW-1:0] DATA_PAD_I,
  output logic [PW-1:0] DATA_PAD_O,
  output logic [PW-1:0] DATA_PAD_OE_N,
  input wire logic [PW-1:0] EXT_ADDR,
  input wire logic [PW-1:0] EXT_DATA_OUT,
  input wire logic EXT_DATA_DRIVE,
  output logic [PW-1:0] EXT_DATA_IN,
  input wire logic [PW-1:0] ADDR_GPIO_OUT,
  output logic [PW-1:0] ADDR_GPIO_IN,
  input wire logic [PW-1:0] DATA_GPIO_OUT,
  output logic [PW-1:0] DATA_GPIO_IN
);
  logic [PW-1:0] apfs_reg;
  logic [PW-1:0] apdir_reg;
  logic [PW-1:0] dpdir_reg;
  logic [PW-1:0] dpfs_reg;
  logic [PW-1:0] addr_in_sync;
  logic [PW-1:0] data_in_sync;
  logic [1:0] mode_sync;
  pcd_mode_t mode_reg;
  logic strap_done_reg;
  logic [1:0] strap_cnt_reg;
  logic ack_reg;
  logic [31:0] dat_o_reg;
  logic req;
  logic wr_take;
  logic rom_off;
  logic [PW-1:0] addr_sel;
  logic [PW-1:0] data_sel;
  logic [31:0] rd_next;

  if (PW != 16) begin : g_bad_pw
    $error("pcd_pfc: PW must be 16, registers are 16 bits wide");
  end

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] wb_merge(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) r[7:0] = wd[7:0];
    if (sel[1]) r[15:8] = wd[15:8];
    return r;
  endfunction

  pcd_sync #(.W(2)) u_mode_sync (
    .clk(CLK),
    .nrst(NRST),
    .d(MODE_PIN),
    .q(mode_sync)
  );

  pcd_sync #(.W(PW)) u_addr_sync (
    .clk(CLK),
    .nrst(NRST),
    .d(ADDR_PAD_I),
    .q(addr_in_sync)
  );

  pcd_sync #(.W(PW)) u_data_sync (
    .clk(CLK),
    .nrst(NRST),
    .d(DATA_PAD_I),
    .q(data_in_sync)
  );

  // Mode straps are latched once the synchroniser has filled after reset.
  // Until then the block behaves as single-chip with all pins inputs.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      mode_reg <= PCD_SINGLE;
    end else if (!strap_done_reg) begin
      if (strap_cnt_reg == `PCD_STRAP_CYC) begin
        strap_done_reg <= 1'b1;
        mode_reg <= pcd_mode_t'(mode_sync);
      end else begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
    end
  end

  // Wishbone classic: ack one cycle after the request, dropped the next cycle
  assign req = WB_CYC_I & WB_STB_I;
  assign wr_take = req & WB_WE_I & ack_reg;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Only NRST, the external power-on reset, clears these registers.
  // No other reset source reaches them, so they hold through the rest.
  // Writes land whatever the mode, so overridden settings are kept.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      apfs_reg <= `PCD_RST_REG;
      apdir_reg <= `PCD_RST_REG;
    end else if (wr_take) begin
      if (WB_ADR_I == `PCD_OFF_APFS) apfs_reg <= wb_merge(apfs_reg, WB_DAT_I, WB_SEL_I);
      if (WB_ADR_I == `PCD_OFF_APDIR) apdir_reg <= wb_merge(apdir_reg, WB_DAT_I, WB_SEL_I);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dpdir_reg <= `PCD_RST_REG;
      dpfs_reg <= `PCD_RST_REG;
    end else if (wr_take) begin
      if (WB_ADR_I == `PCD_OFF_DPDIR) dpdir_reg <= wb_merge(dpdir_reg, WB_DAT_I, WB_SEL_I);
      if (WB_ADR_I == `PCD_OFF_DPFS) dpfs_reg <= wb_merge(dpfs_reg, WB_DAT_I, WB_SEL_I);
    end
  end

  // Read data is captured when the request is first seen; unmapped reads 0
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (WB_ADR_I)
      `PCD_OFF_APFS: rd_next[15:0] = apfs_reg;
      `PCD_OFF_APDIR: rd_next[15:0] = apdir_reg;
      `PCD_OFF_DPDIR: rd_next[15:0] = dpdir_reg;
      `PCD_OFF_DPFS: rd_next[15:0] = dpfs_reg;
      `PCD_OFF_APIN: rd_next[15:0] = addr_in_sync;
      `PCD_OFF_DPIN: rd_next[15:0] = data_in_sync;
      `PCD_OFF_STAT: begin
        rd_next[`PCD_STAT_MODE_MSB:`PCD_STAT_MODE_LSB] = mode_reg;
        rd_next[`PCD_STAT_DONE_BIT] = strap_done_reg;
      end
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dat_o_reg <= 32'h0000_0000;
    end else if (req & ~ack_reg & ~WB_WE_I) begin
      dat_o_reg <= rd_next;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_o_reg;

  // Effective pin function after the mode overrides
  assign rom_off = (mode_reg == PCD_EXT8) | (mode_reg == PCD_EXT16);

  always_comb begin
    unique case (mode_reg)
      PCD_EXT8, PCD_EXT16: addr_sel = '1;
      PCD_EXT_ROM: addr_sel = apfs_reg;
      PCD_SINGLE: addr_sel = '0;
    endcase
  end

  always_comb begin
    unique case (mode_reg)
      PCD_EXT8: data_sel = '1;
      PCD_EXT16: data_sel = '1;
      PCD_EXT_ROM: data_sel = dpfs_reg;
      PCD_SINGLE: data_sel = '0;
    endcase
  end

  // Address lines are outputs whenever selected; general I/O follows its direction bit
  pcd_pin_mux #(.W(PW)) u_addr_mux (
    .clk(CLK),
    .nrst(NRST),
    .func_sel(addr_sel),
    .dir(apdir_reg),
    .gpio_out(ADDR_GPIO_OUT),
    .func_out(EXT_ADDR),
    .func_drive('1),
    .pad_o(ADDR_PAD_O),
    .pad_oe_n(ADDR_PAD_OE_N)
  );

  // Data lines drive only while the bus controller writes; direction bits are unused there
  pcd_pin_mux #(.W(PW)) u_data_mux (
    .clk(CLK),
    .nrst(NRST),
    .func_sel(data_sel),
    .dir(dpdir_reg),
    .gpio_out(DATA_GPIO_OUT),
    .func_out(EXT_DATA_OUT),
    .func_drive({PW{EXT_DATA_DRIVE}}),
    .pad_o(DATA_PAD_O),
    .pad_oe_n(DATA_PAD_OE_N)
  );

  // Inputs are passed through whatever the function; consumers qualify them
  assign ADDR_GPIO_IN = addr_in_sync;
  assign DATA_GPIO_IN = data_in_sync;
  assign EXT_DATA_IN = data_in_sync;

  // ---------------- Assertions ----------------

  property p_bus_ack;
    @(posedge CLK) disable iff (!NRST)
    req && !ack_reg |=> WB_ACK_O ##1 !WB_ACK_O;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("ack not one cycle after request");

  property p_addr_rom_on;
    @(posedge CLK) disable iff (!NRST)
    mode_reg == PCD_EXT_ROM |=>
      ADDR_PAD_O == (($past(EXT_ADDR) & $past(apfs_reg)) | ($past(ADDR_GPIO_OUT) & ~$past(apfs_reg)));
  endproperty
  a_addr_rom_on: assert property (p_addr_rom_on) else $error("address pin mux wrong");

  property p_addr_rom_off;
    @(posedge CLK) disable iff (!NRST)
    rom_off |=> ADDR_PAD_O == $past(EXT_ADDR) && ADDR_PAD_OE_N == '0;
  endproperty
  a_addr_rom_off: assert property (p_addr_rom_off) else $error("address line not forced");

  property p_addr_single;
    @(posedge CLK) disable iff (!NRST)
    mode_reg == PCD_SINGLE |=> ADDR_PAD_O == $past(ADDR_GPIO_OUT) && ADDR_PAD_OE_N == ~$past(apdir_reg);
  endproperty
  a_addr_single: assert property (p_addr_single) else $error("address pin not general I/O");

  property p_addr_dir;
    @(posedge CLK) disable iff (!NRST)
    mode_reg == PCD_EXT_ROM |=>
      (ADDR_PAD_OE_N & ~$past(apfs_reg)) == (~$past(apdir_reg) & ~$past(apfs_reg));
  endproperty
  a_addr_dir: assert property (p_addr_dir) else $error("address direction wrong");

  property p_data_dir;
    @(posedge CLK) disable iff (!NRST)
    mode_reg == PCD_SINGLE |=> DATA_PAD_OE_N == ~$past(dpdir_reg);
  endproperty
  a_data_dir: assert property (p_data_dir) else $error("data direction wrong");

  property p_data_dir_ignored;
    @(posedge CLK) disable iff (!NRST)
    mode_reg == PCD_EXT_ROM |=>
      (DATA_PAD_OE_N & $past(dpfs_reg)) == ({PW{~$past(EXT_DATA_DRIVE)}} & $past(dpfs_reg));
  endproperty
  a_data_dir_ignored: assert property (p_data_dir_ignored) else $error("direction bit leaked");

  property p_dpdir_hold;
    @(posedge CLK) disable iff (!NRST)
    !(wr_take && WB_ADR_I == `PCD_OFF_DPDIR) |=> $stable(dpdir_reg);
  endproperty
  a_dpdir_hold: assert property (p_dpdir_hold) else $error("direction changed w/o write");

  property p_dpfs_hold;
    @(posedge CLK) disable iff (!NRST)
    !(wr_take && WB_ADR_I == `PCD_OFF_DPFS) |=> $stable(dpfs_reg);
  endproperty
  a_dpfs_hold: assert property (p_dpfs_hold) else $error("function changed w/o write");

  property p_data_ext8;
    @(posedge CLK) disable iff (!NRST)
    mode_reg == PCD_EXT8 |=> DATA_PAD_O == $past(EXT_DATA_OUT)
      && DATA_PAD_OE_N == {PW{~$past(EXT_DATA_DRIVE)}};
  endproperty
  a_data_ext8: assert property (p_data_ext8) else $error("8-bit bus not on data pins");

  property p_data_ext16;
    @(posedge CLK) disable iff (!NRST)
    mode_reg == PCD_EXT16 |=> DATA_PAD_O == $past(EXT_DATA_OUT);
  endproperty
  a_data_ext16: assert property (p_data_ext16) else $error("16-bit bus not on data pins");

  property p_data_rom_on;
    @(posedge CLK) disable iff (!NRST)
    mode_reg == PCD_EXT_ROM |=>
      DATA_PAD_O == (($past(EXT_DATA_OUT) & $past(dpfs_reg)) | ($past(DATA_GPIO_OUT) & ~$past(dpfs_reg)));
  endproperty
  a_data_rom_on: assert property (p_data_rom_on) else $error("data pin sharing wrong");

  property p_data_single;
    @(posedge CLK) disable iff (!NRST)
    mode_reg == PCD_SINGLE |=> DATA_PAD_O == $past(DATA_GPIO_OUT);
  endproperty
  a_data_single: assert property (p_data_single) else $error("data pin not general I/O");

  property p_keep_write;
    @(posedge CLK) disable iff (!NRST)
    wr_take && WB_ADR_I == `PCD_OFF_DPFS && WB_SEL_I[1:0] == 2'h3 && mode_reg != PCD_EXT_ROM
      |=> {16'h0000, dpfs_reg} == ($past(WB_DAT_I) & 32'h0000_ffff);
  endproperty
  a_keep_write: assert property (p_keep_write) else $error("overridden write lost");

  property p_data_ext16_oe;
    @(posedge CLK) disable iff (!NRST)
    mode_reg == PCD_EXT16 |=> DATA_PAD_OE_N == {PW{~$past(EXT_DATA_DRIVE)}};
  endproperty
  a_data_ext16_oe: assert property (p_data_ext16_oe) else $error("16-bit bus drive wrong");

  property p_data_rom_gpio;
    @(posedge CLK) disable iff (!NRST)
    mode_reg == PCD_EXT_ROM |=>
      (DATA_PAD_OE_N & ~$past(dpfs_reg)) == (~$past(dpdir_reg) & ~$past(dpfs_reg));
  endproperty
  a_data_rom_gpio: assert property (p_data_rom_gpio) else $error("shared data pin direction wrong");

  // Read data must show the register as it stood when the request was taken
  property p_rd_dpdir;
    @(posedge CLK) disable iff (!NRST)
    req && !ack_reg && !WB_WE_I && WB_ADR_I == `PCD_OFF_DPDIR |=> WB_DAT_O == {16'h0000, $past(dpdir_reg)};
  endproperty
  a_rd_dpdir: assert property (p_rd_dpdir) else $error("direction read data wrong");
endmodule

// file: verif/pcd_pad_load.sv
// Pin loads and external bus devices seen by the address and data port pads
module pcd_pad_load #(
  parameter int W = 16
) (
  input wire logic [W-1:0] addr_pad_o,
  input wire logic [W-1:0] addr_pad_oe_n,
  input wire logic [W-1:0] data_pad_o,
  input wire logic [W-1:0] data_pad_oe_n,
  input wire logic [W-1:0] addr_load,
  input wire logic [W-1:0] data_load,
  output logic [W-1:0] addr_pad_i,
  output logic [W-1:0] data_pad_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released pin shows what the load drives, never the last value the device put out
  assign addr_pad_i = (addr_pad_oe_n & addr_load) | (~addr_pad_oe_n & addr_pad_o);
  // Memory devices drive read data on released data pins
  assign data_pad_i = (data_pad_oe_n & data_load) | (~data_pad_oe_n & data_pad_o);
endmodule

// file: verif/pcd_pfc_tb.sv
// Self-checking testbench of the port C/D pin function block
`include "pcd_defs.svh"
module pcd_pfc_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic WB_WE_I = 1'b0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [3:0] WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 32'h0;
  logic [31:0] WB_DAT_O;
  logic WB_ACK_O;
  logic [1:0] MODE_PIN = 2'h3;
  logic [15:0] ADDR_PAD_I, ADDR_PAD_O, ADDR_PAD_OE_N, DATA_PAD_I, DATA_PAD_O, DATA_PAD_OE_N;
  logic [15:0] EXT_ADDR = 16'h0, EXT_DATA_OUT = 16'h0, EXT_DATA_IN;
  logic EXT_DATA_DRIVE = 1'b0;
  logic [15:0] ADDR_GPIO_OUT = 16'h0, ADDR_GPIO_IN, DATA_GPIO_OUT = 16'h0, DATA_GPIO_IN;
  logic [15:0] addr_load = 16'h0, data_load = 16'h0;
  integer seed = 32221;
  int failures = 0;
  int compares = 0;
  logic [31:0] rd, r, pa, pd;
  logic [15:0] v[10];
  logic drv;

  always #20 CLK = ~CLK;

  pcd_pfc pcd_pfc_i (.CLK(CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .MODE_PIN(MODE_PIN), .ADDR_PAD_I(ADDR_PAD_I), .ADDR_PAD_O(ADDR_PAD_O), .ADDR_PAD_OE_N(ADDR_PAD_OE_N),
    .DATA_PAD_I(DATA_PAD_I), .DATA_PAD_O(DATA_PAD_O), .DATA_PAD_OE_N(DATA_PAD_OE_N), .EXT_ADDR(EXT_ADDR),
    .EXT_DATA_OUT(EXT_DATA_OUT), .EXT_DATA_DRIVE(EXT_DATA_DRIVE), .EXT_DATA_IN(EXT_DATA_IN),
    .ADDR_GPIO_OUT(ADDR_GPIO_OUT), .ADDR_GPIO_IN(ADDR_GPIO_IN), .DATA_GPIO_OUT(DATA_GPIO_OUT),
    .DATA_GPIO_IN(DATA_GPIO_IN));

  pcd_pad_load pcd_pad_load_i (.addr_pad_o(ADDR_PAD_O), .addr_pad_oe_n(ADDR_PAD_OE_N), .data_pad_o(DATA_PAD_O),
    .data_pad_oe_n(DATA_PAD_OE_N), .addr_load(addr_load), .data_load(data_load), .addr_pad_i(ADDR_PAD_I),
    .data_pad_i(DATA_PAD_I));

  task automatic give_verdict;
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single cycle; the wait is bounded so a missing ack cannot hang the run.
  // Only the variant with the port pins is modelled, so register access is legal.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, input logic [3:0] sel,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= adr;
    WB_SEL_I <= sel;
    WB_DAT_I <= d;
    do begin
      @(posedge CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 20);
    chk("wb ack", 32'h1, {31'h0, WB_ACK_O});
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, adr, 32'h0, 4'hf, q);
    chk(what, exp, q);
  endtask

  // Expected {pad out, pad enable low} for one port; drv is the alternate function's drive
  function automatic logic [31:0] pins(input logic [1:0] m, input logic [15:0] fs, input logic [15:0] dir,
                                       input logic [15:0] fo, input logic [15:0] go, input logic drv);
    logic [15:0] sel;
    sel = (m < 2'h2) ? 16'hffff : ((m == 2'h2) ? fs : 16'h0000);
    return {(sel & fo) | (~sel & go), ~((sel & {16{drv}}) | (~sel & dir))};
  endfunction

  function automatic logic [31:0] lvl(input logic [31:0] p, input logic [15:0] load);
    return {16'h0, (p[15:0] & load) | (~p[15:0] & p[31:16])};
  endfunction

  initial begin
    repeat (20000) @(posedge CLK);
    failures++;
    $display("ERROR watchdog expected done seen hang");
    give_verdict;
  end

  initial begin
    for (int m = 0; m < 4; m++) begin
      @(posedge CLK);
      NRST <= 1'b0;
      MODE_PIN <= m[1:0];
      repeat (2) @(posedge CLK);
      chk("ack in reset", 32'h0, {31'h0, WB_ACK_O});
      chk("oe_n in reset", 32'hffffffff, {ADDR_PAD_OE_N, DATA_PAD_OE_N});
      NRST <= 1'b1;
      repeat (6) @(posedge CLK);
      rdchk("status", `PCD_OFF_STAT, {29'h0, 1'b1, m[1:0]});
      rdchk("apfs reset", `PCD_OFF_APFS, 32'h0);
      rdchk("dpdir reset", `PCD_OFF_DPDIR, 32'h0);
      rdchk("dpfs reset", `PCD_OFF_DPFS, 32'h0);
      wb(1'b1, `PCD_OFF_DPDIR, 32'h0000a5c3, 4'h1, rd);
      rdchk("dpdir lane", `PCD_OFF_DPDIR, 32'h000000c3);
      wb(1'b1, 8'h1c, 32'hffffffff, 4'hf, rd);
      rdchk("unmapped", 8'h1c, 32'h0);
      for (int i = 0; i < 8; i++) begin
        foreach (v[k]) begin
          r = $random(seed);
          v[k] = (i == 0) ? 16'hffff : ((i == 1) ? 16'h0000 : r[15:0]);
        end
        drv = (i < 2) ? 1'b0 : r[20];
        wb(1'b1, `PCD_OFF_APFS, {16'h0, v[0]}, 4'h3, rd);
        wb(1'b1, `PCD_OFF_APDIR, {16'h0, v[1]}, 4'h3, rd);
        wb(1'b1, `PCD_OFF_DPDIR, {16'h0, v[2]}, 4'h3, rd);
        wb(1'b1, `PCD_OFF_DPFS, {16'h0, v[3]}, 4'h3, rd);
        rdchk("apfs", `PCD_OFF_APFS, {16'h0, v[0]});
        rdchk("apdir", `PCD_OFF_APDIR, {16'h0, v[1]});
        rdchk("dpdir", `PCD_OFF_DPDIR, {16'h0, v[2]});
        rdchk("dpfs", `PCD_OFF_DPFS, {16'h0, v[3]});
        @(posedge CLK);
        EXT_ADDR <= v[4];
        EXT_DATA_OUT <= v[5];
        ADDR_GPIO_OUT <= v[6];
        DATA_GPIO_OUT <= v[7];
        addr_load <= v[8];
        data_load <= v[9];
        EXT_DATA_DRIVE <= drv;
        repeat (7) @(posedge CLK);
        pa = pins(m[1:0], v[0], v[1], v[4], v[6], 1'b1);
        pd = pins(m[1:0], v[3], v[2], v[5], v[7], drv);
        chk("addr oe_n", {16'h0, pa[15:0]}, {16'h0, ADDR_PAD_OE_N});
        chk("addr out", {16'h0, pa[31:16] & ~pa[15:0]}, {16'h0, ADDR_PAD_O & ~pa[15:0]});
        chk("data oe_n", {16'h0, pd[15:0]}, {16'h0, DATA_PAD_OE_N});
        chk("data out", {16'h0, pd[31:16] & ~pd[15:0]}, {16'h0, DATA_PAD_O & ~pd[15:0]});
        chk("addr gpio in", lvl(pa, v[8]), {16'h0, ADDR_GPIO_IN});
        chk("data gpio in", lvl(pd, v[9]), {16'h0, DATA_GPIO_IN});
        chk("ext data in", lvl(pd, v[9]), {16'h0, EXT_DATA_IN});
        rdchk("apin", `PCD_OFF_APIN, lvl(pa, v[8]));
        rdchk("dpin", `PCD_OFF_DPIN, lvl(pd, v[9]));
      end
    end
    give_verdict;
  end
endmodule
